// [logic/ncr_defines.svh]
`ifndef NCR_DEFINES_SVH
`define NCR_DEFINES_SVH
// core command register address within every page
`define NCR_ADDR_CMD 4'h0
// field positions
`define NCR_HALT_POS 0
`define NCR_RUN_POS 1
`define NCR_LAUNCH_POS 2
`define NCR_RDMA_LO 3
`define NCR_RDMA_HI 5
`define NCR_RDMA_ABORT_POS 5
`define NCR_PAGE_LO 6
`define NCR_PAGE_HI 7
// reset value: halt high, run low, everything else zero
`define NCR_CMD_RESET 8'h01
`define NCR_STATUS_RST_POS 7
`define NCR_RDMA_NOP 3'h0
`define NCR_RDMA_NONE 3'h0
`endif

// [logic/ncr_pkg.sv]
package ncr_pkg;
    typedef enum logic [2:0] {
        NCR_RDMA_ILLEGAL = 3'h0,
        NCR_RDMA_READ = 3'h1,
        NCR_RDMA_WRITE = 3'h2,
        NCR_RDMA_SEND = 3'h3,
        NCR_RDMA_ABORT = 3'h4
    } ncr_rdma_t;
    typedef enum logic [1:0] {
        NCR_ST_RESET = 2'h0,
        NCR_ST_RUN = 2'h1,
        NCR_ST_DRAIN = 2'h2
    } ncr_state_t;
endpackage

// [logic/ncr_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module ncr_sync (
    // clock and reset
    input wire logic sysClk,
    input wire logic rst_n,
    // level in and agreed level out
    input wire logic asyncIn,
    output logic syncOut
);
    logic s1Q;
    logic s2Q;
    logic s3Q;
    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            s1Q <= 1'b0;
            s2Q <= 1'b0;
            s3Q <= 1'b0;
        end else begin
            s1Q <= asyncIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
        end
    end
    // a change counts once the second and third stages agree
    always_ff @(posedge sysClk or negedge rst_n) begin
        if (!rst_n) begin
            syncOut <= 1'b0;
        end else if (s2Q == s3Q) begin
            syncOut <= s3Q;
        end
    end
endmodule
`default_nettype wire

// [logic/ncr_command.sv]
// How it works
// - reissued dma with launch completes at once unless count reloaded
// - writing launch zero leaves transmission alone
// - page, abort, halt bits writable any time
// - halt takes core off-line
// - frames in progress finish before reset
// - leave reset only on halt clear, run set
// - reset-status flag marks halt done
// - halt while running reads both set
// - run bit activates core from reset
// - launch starts frame, self-clears on end
// - dma field decode read write send abort
// - abort bit ends dma in progress
// - abort keeps current remote start address
// - page field selects register page
// - reset flag set on entry, cleared by start
// - eight-bit registers, four address lines
`timescale 1ns/1ps
`default_nettype none
`include "ncr_defines.svh"
module ncr_command (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port, pins from the host bus
    input wire logic [3:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regRdataValid,
    // status from the transmit engine, same clock
    input wire logic txBusy,
    input wire logic txDone,
    input wire logic txAbort,
    // status from the receive path, same clock
    input wire logic rxBusy,
    // status from the remote dma engine, same clock
    input wire logic rdmaDone,
    input wire logic rdmaCountReloaded,
    // line that marks a receive ring overflow, from outside the clock domain
    input wire logic ringOverflowPin,
    // controls to the rest of the core
    output logic [1:0] pageSelect,
    output logic txLaunchReq,
    output logic [2:0] rdmaCmd,
    output logic rdmaActive,
    output logic rdmaFinishNow,
    output logic coreOnline,
    output logic resetStatus
);
    // ****************************************
    // decode helpers
    // ****************************************
    function automatic ncr_pkg::ncr_rdma_t decodeRdma(input logic [2:0] code);
        if (code[`NCR_RDMA_ABORT_POS - `NCR_RDMA_LO]) begin
            decodeRdma = ncr_pkg::NCR_RDMA_ABORT;
        end else begin
            decodeRdma = ncr_pkg::ncr_rdma_t'(code);
        end
    endfunction
    function automatic logic isRdmaRun(input logic [2:0] code);
        ncr_pkg::ncr_rdma_t k;
        k = decodeRdma(code);
        isRdmaRun = (k == ncr_pkg::NCR_RDMA_READ) || (k == ncr_pkg::NCR_RDMA_WRITE)
            || (k == ncr_pkg::NCR_RDMA_SEND);
    endfunction

    // ****************************************
    // write decode
    // ****************************************
    logic cmdWrite;
    logic [2:0] wrRdma;
    logic ovfSync;
    assign cmdWrite = regWrite && (regAddr == `NCR_ADDR_CMD);
    assign wrRdma = regWdata[`NCR_RDMA_HI:`NCR_RDMA_LO];

    ncr_sync uOvfSync (
        .sysClk(sys_clk),
        .rst_n(rst_n),
        .asyncIn(ringOverflowPin),
        .syncOut(ovfSync)
    );

    // ****************************************
    // command register bits
    // ****************************************
    logic haltQ;
    logic runQ;
    logic launchQ;
    logic [2:0] rdmaQ;
    logic [1:0] pageQ;
    logic rdmaActiveQ;
    ncr_pkg::ncr_state_t stateQ;
    localparam logic [7:0] CmdReset = `NCR_CMD_RESET;

    // page field accepted on every command register write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pageQ <= 2'h0;
        end else if (cmdWrite) begin
            pageQ <= regWdata[`NCR_PAGE_HI:`NCR_PAGE_LO];
        end
    end

    // halt and run bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            haltQ <= CmdReset[`NCR_HALT_POS];
            runQ <= CmdReset[`NCR_RUN_POS];
        end else if (cmdWrite) begin
            haltQ <= regWdata[`NCR_HALT_POS];
            // run stays set when halt is written over a running core
            if (regWdata[`NCR_RUN_POS]) begin
                runQ <= 1'b1;
            end else if (!regWdata[`NCR_HALT_POS]) begin
                runQ <= 1'b0;
            end else begin
                runQ <= runQ;
            end
        end
    end

    // core state machine; a halt waits for both engines to go idle
    logic enginesIdle;
    assign enginesIdle = !txBusy && !rxBusy;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= ncr_pkg::NCR_ST_RESET;
        end else begin
            unique case (stateQ)
                ncr_pkg::NCR_ST_RESET: begin
                    if (!haltQ && runQ) begin
                        stateQ <= ncr_pkg::NCR_ST_RUN;
                    end
                end
                ncr_pkg::NCR_ST_RUN: begin
                    if (haltQ) begin
                        stateQ <= ncr_pkg::NCR_ST_DRAIN;
                    end
                end
                ncr_pkg::NCR_ST_DRAIN: begin
                    if (enginesIdle) begin
                        stateQ <= ncr_pkg::NCR_ST_RESET;
                    end
                end
                default: begin
                    stateQ <= ncr_pkg::NCR_ST_RESET;
                end
            endcase
        end
    end

    // launch bit: set by host while online, cleared by hardware at end
    logic launchSet;
    assign launchSet = cmdWrite && regWdata[`NCR_LAUNCH_POS]
        && (stateQ == ncr_pkg::NCR_ST_RUN) && !haltQ;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            launchQ <= 1'b0;
        end else if (launchSet) begin
            launchQ <= 1'b1;
        end else if (txDone || txAbort) begin
            launchQ <= 1'b0;
        end
        // a zero written to the launch bit changes nothing
    end

    // remote dma command field and activity
    logic abortWrite;
    assign abortWrite = cmdWrite && regWdata[`NCR_RDMA_ABORT_POS];
    logic rdmaReissue;
    assign rdmaReissue = cmdWrite && regWdata[`NCR_LAUNCH_POS] && rdmaActiveQ
        && (wrRdma == rdmaQ) && !rdmaCountReloaded;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdmaQ <= `NCR_RDMA_NONE;
        end else if (cmdWrite) begin
            rdmaQ <= wrRdma;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdmaActiveQ <= 1'b0;
        end else if (abortWrite) begin
            rdmaActiveQ <= 1'b0;
        end else if (rdmaReissue) begin
            rdmaActiveQ <= 1'b0;
        end else if (cmdWrite && isRdmaRun(wrRdma)) begin
            rdmaActiveQ <= 1'b1;
        end else if (rdmaDone) begin
            rdmaActiveQ <= 1'b0;
        end
    end

    // finish strobe to the dma engine; it keeps its address
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdmaFinishNow <= 1'b0;
        end else begin
            rdmaFinishNow <= (abortWrite && rdmaActiveQ) || rdmaReissue;
        end
    end

    // ****************************************
    // reset status flag
    // ****************************************
    // a start command clears the flag, also after a ring overflow while running
    logic rstFlagQ;
    logic startWrite;
    assign startWrite = cmdWrite && regWdata[`NCR_RUN_POS] && !regWdata[`NCR_HALT_POS];
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstFlagQ <= 1'b1;
        end else if (stateQ == ncr_pkg::NCR_ST_DRAIN && enginesIdle) begin
            rstFlagQ <= 1'b1;
        end else if (ovfSync) begin
            rstFlagQ <= 1'b1;
        end else if (startWrite || (stateQ == ncr_pkg::NCR_ST_RESET && !haltQ && runQ)) begin
            rstFlagQ <= 1'b0;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
            regRdataValid <= 1'b0;
        end else begin
            regRdataValid <= regRead && (regAddr == `NCR_ADDR_CMD);
            if (regRead && (regAddr == `NCR_ADDR_CMD)) begin
                regRdata <= {pageQ, rdmaQ, launchQ, runQ, haltQ};
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pageSelect <= 2'h0;
            txLaunchReq <= 1'b0;
            rdmaCmd <= `NCR_RDMA_NONE;
            rdmaActive <= 1'b0;
            coreOnline <= 1'b0;
            resetStatus <= 1'b1;
        end else begin
            pageSelect <= pageQ;
            txLaunchReq <= launchQ;
            rdmaCmd <= rdmaQ;
            rdmaActive <= rdmaActiveQ;
            coreOnline <= (stateQ == ncr_pkg::NCR_ST_RUN) && !haltQ;
            resetStatus <= rstFlagQ;
        end
    end
endmodule
`default_nettype wire

// [sim/ncr_command_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ncr_command_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    input wire logic regRdataValid,
    // engine status
    input wire logic txBusy,
    input wire logic txDone,
    input wire logic ringOverflowPin,
    // controls
    input wire logic [1:0] pageSelect,
    input wire logic txLaunchReq,
    input wire logic [2:0] rdmaCmd,
    input wire logic rdmaActive,
    input wire logic rdmaFinishNow,
    input wire logic coreOnline,
    input wire logic resetStatus
);
    // ***
    // command checks
    // ***
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic cmdWr = regWrite && regAddr == 4'h0;
    property p_read; regRead && regAddr == 4'h0 |=> regRdataValid; endproperty
    a_read: assert property (p_read) else $error("read unanswered");
    property p_page; cmdWr |-> ##2 pageSelect == $past(regWdata[7:6], 2); endproperty
    a_page: assert property (p_page) else $error("page wrong");
    property p_code;
        cmdWr && regWdata[5:2] inside {4'h2, 4'h4, 4'h6} |-> ##2 rdmaCmd == $past(regWdata[5:3], 2);
    endproperty
    a_code: assert property (p_code) else $error("dma code wrong");
    property p_drain; txBusy && !resetStatus |=> !resetStatus; endproperty
    a_drain: assert property (p_drain) else $error("reset before idle");
    property p_start; cmdWr && regWdata[1:0] == 2'b10 && !ringOverflowPin |-> ##3 !resetStatus;
    endproperty
    a_start: assert property (p_start) else $error("flag not cleared");
    property p_refuse; !coreOnline [*4] |=> !$rose(txLaunchReq); endproperty
    a_refuse: assert property (p_refuse) else $error("launch offline");
    property p_clear; txDone |-> ##[1:3] !txLaunchReq; endproperty
    a_clear: assert property (p_clear) else $error("launch kept");
    property p_abort; cmdWr && regWdata[5] && rdmaActive |-> ##[1:3] rdmaFinishNow; endproperty
    a_abort: assert property (p_abort) else $error("abort ignored");
    property p_pulse; rdmaFinishNow |=> !rdmaFinishNow; endproperty
    a_pulse: assert property (p_pulse) else $error("finish too long");
endmodule
bind ncr_command ncr_command_properties u_props (.sys_clk, .rst_n, .regAddr, .regWrite,
    .regRead, .regWdata, .regRdataValid, .txBusy, .txDone, .ringOverflowPin, .pageSelect,
    .txLaunchReq, .rdmaCmd, .rdmaActive, .rdmaFinishNow, .coreOnline, .resetStatus);
`default_nettype wire

// [sim/ncr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ncr_host_model (
    // clock
    input wire logic sys_clk,
    // register port
    output logic [3:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic regRdataValid
);
    // ***
    // host cycles
    // ***
    logic [2:0] runCode = 3'h0;
    initial begin
        regAddr = 4'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 8'h00;
    end
    task automatic wrAt(input logic [3:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge sys_clk);
        regWrite = 1'b0;
        regAddr = 4'h0;
        regWdata = ~d;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] d);
        wrAt(4'h0, d);
    endtask
    task automatic rd(output logic [7:0] v);
        @(negedge sys_clk);
        regRead = 1'b1;
        @(negedge sys_clk);
        v = (regRdataValid === 1'b1) ? regRdata : 8'hXX;
        regRead = 1'b0;
    endtask
    // a running transfer with a different code is aborted first
    task automatic dma(input logic [2:0] c);
        if (runCode != 3'h0 && runCode != c && !c[2]) wr(8'h22);
        wr({2'b00, c, 3'b010});
        runCode = c[2] ? 3'h0 : c;
    endtask
    // writes run and launch with the running dma code, or the abort code when none runs
    task automatic launch();
        wr({2'b00, ((runCode == 3'h0) ? 3'h4 : runCode), 3'b110});
    endtask
endmodule
`default_nettype wire

// [sim/nic_command_register_test.sv]
`timescale 1ns/1ps
`default_nettype none
module nic_command_register_test;
    // ***
    // bench
    // ***
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic txBusy = 1'b0;
    logic txDone = 1'b0;
    logic txAbort = 1'b0;
    logic rxBusy = 1'b0;
    logic rdmaDone = 1'b0;
    logic rdmaCountReloaded = 1'b0;
    logic ringOverflowPin = 1'b0;
    logic [3:0] regAddr;
    logic regWrite, regRead, regRdataValid, txLaunchReq, rdmaActive;
    logic rdmaFinishNow, coreOnline, resetStatus;
    logic [7:0] regWdata, regRdata, v;
    logic [1:0] pageSelect;
    logic [2:0] rdmaCmd;
    int err_total = 0;
    int n_compared = 0;
    int finSeen = 0;
    int txCnt = 0;
    int f0;
    logic abortNext = 1'b0;
    initial forever #2 sys_clk = ~sys_clk;
    ncr_host_model u_host (.sys_clk, .regAddr, .regWrite, .regRead, .regWdata, .regRdata,
        .regRdataValid);
    ncr_command u_dut (.sys_clk, .rst_n, .regAddr, .regWrite, .regRead, .regWdata, .regRdata,
        .regRdataValid, .txBusy, .txDone, .txAbort, .rxBusy, .rdmaDone, .rdmaCountReloaded,
        .ringOverflowPin, .pageSelect, .txLaunchReq, .rdmaCmd, .rdmaActive, .rdmaFinishNow,
        .coreOnline, .resetStatus);
    always @(posedge sys_clk) if (rdmaFinishNow === 1'b1) finSeen <= finSeen + 1;
    // transmit engine: 20 busy cycles per launch, then a done or abort pulse
    always @(negedge sys_clk) begin
        txDone <= 1'b0;
        txAbort <= 1'b0;
        if (txBusy) begin
            txCnt <= txCnt - 1;
            if (txCnt == 1) begin
                txBusy <= 1'b0;
                txDone <= !abortNext;
                txAbort <= abortNext;
                txCnt <= -4;
            end
        end else if (txCnt < 0) begin
            txCnt <= txCnt + 1;
        end else if (txLaunchReq === 1'b1) begin
            txBusy <= 1'b1;
            txCnt <= 20;
        end
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic donePulse();
        @(negedge sys_clk);
        rdmaDone = 1'b1;
        @(negedge sys_clk);
        rdmaDone = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic waitfor(input int sel);
        for (int i = 0; i < 200; i++) begin
            @(negedge sys_clk);
            if ((sel == 0 && txLaunchReq === 1'b0) || (sel == 1 && resetStatus === 1'b1)) return;
        end
        err_total++;
        $display("ERROR %0t timeout", $time);
        final_report;
    endtask
    task automatic final_report;
        if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        u_host.rd(v);
        cmp(v, 8'h01);
        cmp(8'(resetStatus), 8'h01);
        u_host.wr(8'h02);
        cmp(8'(coreOnline), 8'h01);
        cmp(8'(resetStatus), 8'h00);
        for (int p = 0; p < 4; p++) begin
            u_host.wr({p[1:0], 6'h22});
            u_host.rd(v);
            cmp({6'h00, pageSelect}, p[7:0]);
            cmp({6'h00, v[7:6]}, p[7:0]);
        end
        u_host.wrAt(4'h7, 8'h00);
        cmp({6'h00, pageSelect}, 8'h03);
        for (int c = 1; c < 5; c++) begin
            f0 = finSeen;
            u_host.dma(c[2:0]);
            cmp(8'(finSeen - f0), (c > 1) ? 8'h01 : 8'h00);
            cmp(8'(rdmaActive), (c < 4) ? 8'h01 : 8'h00);
            if (c < 4) cmp({5'h00, rdmaCmd}, c[7:0]);
        end
        u_host.dma(3'h2);
        donePulse();
        cmp(8'(rdmaActive), 8'h00);
        f0 = finSeen;
        u_host.dma(3'h1);
        u_host.launch();
        cmp(8'(finSeen - f0), 8'h01);
        cmp(8'(txLaunchReq), 8'h01);
        u_host.dma(3'h4);
        cmp(8'(txLaunchReq), 8'h01);
        waitfor(0);
        cmp(8'(txLaunchReq), 8'h00);
        abortNext = 1'b1;
        rdmaCountReloaded = 1'b1;
        f0 = finSeen;
        u_host.dma(3'h1);
        u_host.launch();
        cmp(8'(finSeen - f0), 8'h00);
        cmp(8'(rdmaActive), 8'h01);
        waitfor(0);
        cmp(8'(txLaunchReq), 8'h00);
        abortNext = 1'b0;
        rdmaCountReloaded = 1'b0;
        u_host.dma(3'h4);
        cmp(8'(finSeen - f0), 8'h01);
        donePulse();
        cmp(8'(rdmaActive), 8'h00);
        u_host.launch();
        rxBusy = 1'b1;
        u_host.wr(8'h03);
        cmp(8'(resetStatus), 8'h00);
        u_host.rd(v);
        cmp(v & 8'h03, 8'h03);
        waitfor(0);
        repeat (4) @(negedge sys_clk);
        cmp(8'(resetStatus), 8'h00);
        rxBusy = 1'b0;
        waitfor(1);
        cmp(8'(coreOnline), 8'h00);
        u_host.wr(8'h05);
        cmp(8'(txLaunchReq), 8'h00);
        u_host.wr(8'h02);
        cmp(8'(resetStatus), 8'h00);
        ringOverflowPin = 1'b1;
        waitfor(1);
        ringOverflowPin = 1'b0;
        repeat (10) @(negedge sys_clk);
        u_host.wr(8'h02);
        cmp(8'(resetStatus), 8'h00);
        final_report;
    end
endmodule
`default_nettype wire
